//--- compare_skip_defs.svh
// Constants for the compare-and-skip execution block
// Functional notes
// - Compare file byte with working register unsigned; no flags, no result stored.
// - Greater opcode 0110 010a: skip next instruction when byte exceeds working register.
// - Less opcode 0110 000a: skip next instruction when byte is below working register.
// - Access bit zero uses access bank; one uses bank select register bank.
// - Extended set, access bit zero, address up to 95: indexed literal offset.
// - One word; one cycle, two when skipping, three over two-word instruction.
// - Q1 decode, Q2 read, Q3 process, Q4 no write; skip cycles idle.
`ifndef COMPARE_SKIP_DEFS_SVH
`define COMPARE_SKIP_DEFS_SVH

`define CS_OPC_GREATER     7'h32
`define CS_OPC_LESS        7'h30
`define CS_OPC_MSB         15
`define CS_OPC_LSB         9
`define CS_ACCESS_BIT      8
`define CS_FILE_MSB        7
`define CS_FILE_LSB        0
`define CS_INDEXED_LIMIT   8'h5f
`define CS_ACCESS_SPLIT    8'h60
`define CS_ACCESS_LOW_PAGE 4'h0
`define CS_ACCESS_HIGH_PAGE 4'hf
`define CS_PHASE_Q1        4'h1
`define CS_CYCLES_PLAIN    2'h1
`define CS_CYCLES_SKIP     2'h2
`define CS_CYCLES_SKIP_TWO 2'h3
`define CS_CYCLES_RESET    2'h0

`endif

//--- compare_skip_if.sv
// Operand and comparison signals between sequencer and compare unit
`timescale 1ns/1ns
interface compare_skip_if #(
    parameter int unsigned AW = 12,
    parameter int unsigned BW = 4
);
    logic [7:0]    fileField;
    logic          accessBit;
    logic [BW-1:0] bankSel;
    logic [AW-1:0] indexBase;
    logic          extEnable;
    compare_skip_pkg::kind_e kind;
    logic [7:0]    operand;
    logic [7:0]    working;
    logic [AW-1:0] address;
    logic          indexed;
    logic          skip;

    modport core (
        output fileField, accessBit, bankSel, indexBase, extEnable, kind, operand, working,
        input  address, indexed, skip
    );
    modport unit (
        input  fileField, accessBit, bankSel, indexBase, extEnable, kind, operand, working,
        output address, indexed, skip
    );
endinterface

//--- compare_skip_instructions.sv
// Sequencer for the compare-and-skip instructions over four quarters
`timescale 1ns/1ns
`include "compare_skip_defs.svh"
module compare_skip_instructions #(
    parameter int unsigned AW = 12,
    parameter int unsigned BW = 4
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Instruction from fetch
    input  wire logic [15:0]                 instrWord,
    input  wire logic                        instrValid,
    input  wire logic                        nextTwoWord,
    // Core state
    input  wire logic [7:0]                  workingReg,
    input  wire logic [BW-1:0]               bankSelect,
    input  wire logic [AW-1:0]               indexBase,
    input  wire logic                        extEnable,
    // Data memory
    output logic [AW-1:0]                    dataAddr,
    output logic                             readStrobe,
    input  wire logic [7:0]                  dataIn,
    output logic                             resultWrite,
    output logic                             statusWrite,
    // Sequencing
    output logic [3:0]                       quarter,
    output compare_skip_pkg::activity_e      activity,
    output logic                             busy,
    output logic                             done,
    output logic                             skipTaken,
    output logic                             flushFetched,
    output logic                             nopCycle,
    output logic                             indexedMode,
    output logic [1:0]                       cycleCount
);
    compare_skip_pkg::state_e    state_q, state_d;
    compare_skip_pkg::kind_e     kind_q;
    compare_skip_pkg::activity_e activity_q, activity_d;
    logic [3:0]    phase_q;
    logic          active_q;
    logic [7:0]    file_q;
    logic          access_q;
    logic          skip_q;
    logic          twoWord_q;
    logic [AW-1:0] dataAddr_q;
    logic          readStrobe_q;
    logic          indexed_q;
    logic          done_q;
    logic          skipTaken_q;
    logic          flush_q;
    logic          nopCycle_q;
    logic [1:0]    cycles_q;
    logic          resultWrite_q;
    logic          statusWrite_q;

    logic [6:0]    opcode;
    logic          isGreater;
    logic          isLess;
    logic          accept;
    logic          inQ1;
    logic          inQ2;
    logic          inQ3;
    logic          inQ4;

    compare_skip_if #(.AW(AW), .BW(BW)) cs ();

    compare_skip_unit #(.AW(AW), .BW(BW)) unit (
        .cs (cs)
    );

    assign inQ1 = phase_q[0];
    assign inQ2 = phase_q[1];
    assign inQ3 = phase_q[2];
    assign inQ4 = phase_q[3];

    // Opcode decode in the first quarter
    assign opcode    = instrWord[`CS_OPC_MSB:`CS_OPC_LSB];
    assign isGreater = (opcode == `CS_OPC_GREATER);
    assign isLess    = (opcode == `CS_OPC_LESS);
    assign accept    = inQ1 && instrValid && (isGreater || isLess)
                       && (state_q == compare_skip_pkg::ST_RUN);

    assign cs.fileField = file_q;
    assign cs.accessBit = access_q;
    assign cs.bankSel   = bankSelect;
    assign cs.indexBase = indexBase;
    assign cs.extEnable = extEnable;
    assign cs.kind      = kind_q;
    assign cs.operand   = dataIn;
    assign cs.working   = workingReg;

    // Skip cycles follow a taken compare; a second one covers a two-word successor
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            compare_skip_pkg::ST_RUN: begin
                if (active_q && inQ4 && skip_q) begin
                    state_d = compare_skip_pkg::ST_SKIP;
                end
            end
            compare_skip_pkg::ST_SKIP: begin
                if (inQ4) begin
                    state_d = twoWord_q ? compare_skip_pkg::ST_SKIP_SECOND
                                        : compare_skip_pkg::ST_RUN;
                end
            end
            compare_skip_pkg::ST_SKIP_SECOND: begin
                if (inQ4) begin
                    state_d = compare_skip_pkg::ST_RUN;
                end
            end
        endcase
    end

    // Activity of the current quarter, reported one clock later
    always_comb begin
        activity_d = compare_skip_pkg::ACT_NOP;
        if (state_q == compare_skip_pkg::ST_RUN) begin
            if (accept) begin
                activity_d = compare_skip_pkg::ACT_DECODE;
            end else if (active_q && inQ2) begin
                activity_d = compare_skip_pkg::ACT_READ;
            end else if (active_q && inQ3) begin
                activity_d = compare_skip_pkg::ACT_PROCESS;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= `CS_PHASE_Q1;
        end else begin
            phase_q <= {phase_q[2:0], phase_q[3]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q    <= compare_skip_pkg::ST_RUN;
            activity_q <= compare_skip_pkg::ACT_NOP;
            nopCycle_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            activity_q <= activity_d;
            nopCycle_q <= (state_d != compare_skip_pkg::ST_RUN);
        end
    end

    // Latch operand fields at decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            file_q   <= 8'h00;
            access_q <= 1'b0;
            kind_q   <= compare_skip_pkg::KIND_LESS;
        end else if (accept) begin
            active_q <= 1'b1;
            file_q   <= instrWord[`CS_FILE_MSB:`CS_FILE_LSB];
            access_q <= instrWord[`CS_ACCESS_BIT];
            kind_q   <= isGreater ? compare_skip_pkg::KIND_GREATER
                                  : compare_skip_pkg::KIND_LESS;
        end else if (inQ4) begin
            active_q <= 1'b0;
        end
    end

    // Second quarter: one read of the file register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataAddr_q   <= '0;
            readStrobe_q <= 1'b0;
            indexed_q    <= 1'b0;
        end else begin
            readStrobe_q <= active_q && inQ2;
            if (active_q && inQ2) begin
                dataAddr_q <= cs.address;
                indexed_q  <= cs.indexed;
            end
        end
    end

    // Third quarter: compare with the returned byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            skip_q <= 1'b0;
        end else if (active_q && inQ3) begin
            skip_q <= cs.skip;
        end
    end

    // Fourth quarter: nothing written, outcome announced
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q      <= 1'b0;
            skipTaken_q <= 1'b0;
            flush_q     <= 1'b0;
            twoWord_q   <= 1'b0;
        end else begin
            done_q      <= active_q && inQ4;
            skipTaken_q <= active_q && inQ4 && skip_q;
            flush_q     <= active_q && inQ4 && skip_q;
            if (active_q && inQ4) begin
                twoWord_q <= nextTwoWord;
            end
        end
    end

    // Cycles used by the last compare
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycles_q <= `CS_CYCLES_RESET;
        end else if (active_q && inQ4 && !skip_q) begin
            cycles_q <= `CS_CYCLES_PLAIN;
        end else if (inQ4 && state_q == compare_skip_pkg::ST_SKIP && !twoWord_q) begin
            cycles_q <= `CS_CYCLES_SKIP;
        end else if (inQ4 && state_q == compare_skip_pkg::ST_SKIP_SECOND) begin
            cycles_q <= `CS_CYCLES_SKIP_TWO;
        end
    end

    // Flags and destination are never written by these instructions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultWrite_q <= 1'b0;
            statusWrite_q <= 1'b0;
        end else begin
            resultWrite_q <= 1'b0;
            statusWrite_q <= 1'b0;
        end
    end

    assign dataAddr     = dataAddr_q;
    assign readStrobe   = readStrobe_q;
    assign resultWrite  = resultWrite_q;
    assign statusWrite  = statusWrite_q;
    assign quarter      = phase_q;
    assign activity     = activity_q;
    assign busy         = active_q;
    assign done         = done_q;
    assign skipTaken    = skipTaken_q;
    assign flushFetched = flush_q;
    assign nopCycle     = nopCycle_q;
    assign indexedMode  = indexed_q;
    assign cycleCount   = cycles_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_idleCycle;
        nopCycle_q && !readStrobe_q && !active_q;
    endsequence

    sequence s_skipOne;
        s_idleCycle [*4];
    endsequence

    a_no_writeback: assert property (!resultWrite_q && !statusWrite_q)
        else $error("compare wrote a result or flags");

    a_greater_skip: assert property (
        (active_q && inQ3 && kind_q == compare_skip_pkg::KIND_GREATER)
        |=> skip_q == ($past(dataIn) > $past(workingReg)) ##1 flush_q == skip_q)
        else $error("greater compare skip decision wrong");

    a_less_skip: assert property (
        (active_q && inQ3 && kind_q == compare_skip_pkg::KIND_LESS)
        |=> skip_q == ($past(dataIn) < $past(workingReg)) ##1 skipTaken_q == skip_q)
        else $error("less compare skip decision wrong");

    a_bank_address: assert property (
        (active_q && inQ2 && access_q)
        |=> dataAddr_q == AW'({$past(bankSelect), $past(file_q)}) && !indexed_q)
        else $error("banked operand address wrong");

    a_indexed_address: assert property (
        (active_q && inQ2 && !access_q && extEnable && file_q <= `CS_INDEXED_LIMIT)
        |=> indexed_q && dataAddr_q == AW'($past(indexBase) + AW'($past(file_q))))
        else $error("indexed literal offset address wrong");

    a_skip_cycles: assert property (
        (done_q && skipTaken_q && !twoWord_q) |-> s_skipOne ##1 cycles_q == `CS_CYCLES_SKIP)
        else $error("single skip did not take two cycles");

    a_skip_two_word: assert property (
        (done_q && skipTaken_q && twoWord_q) |-> s_skipOne ##1 s_skipOne
        ##1 (cycles_q == `CS_CYCLES_SKIP_TWO && !nopCycle_q))
        else $error("skip over two-word instruction did not take three cycles");

    a_plain_cycle: assert property (
        (done_q && !skipTaken_q) |-> cycles_q == `CS_CYCLES_PLAIN && !nopCycle_q)
        else $error("non-skipping compare did not take one cycle");

    a_read_quarter: assert property (
        readStrobe_q |-> inQ3 && $past(inQ2) && activity_q == compare_skip_pkg::ACT_READ)
        else $error("file read outside the second quarter");

endmodule

//--- compare_skip_pkg.sv
// Types shared by the compare-and-skip block
package compare_skip_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SKIP,
        ST_SKIP_SECOND
    } state_e;

    typedef enum logic {
        KIND_LESS,
        KIND_GREATER
    } kind_e;

    typedef enum logic [1:0] {
        ACT_NOP,
        ACT_DECODE,
        ACT_READ,
        ACT_PROCESS
    } activity_e;

endpackage

//--- compare_skip_unit.sv
// Operand address resolution and unsigned compare
`timescale 1ns/1ns
`include "compare_skip_defs.svh"
module compare_skip_unit #(
    parameter int unsigned AW = 12,
    parameter int unsigned BW = 4
) (
    compare_skip_if.unit cs
);
    logic [8:0]    difference;
    logic          borrow;
    logic          equal;
    logic          useIndexed;
    logic [AW-1:0] accessAddr;
    logic [AW-1:0] bankAddr;
    logic [AW-1:0] indexAddr;

    // Unsigned subtraction; result only steers the skip
    assign difference = {1'b0, cs.operand} - {1'b0, cs.working};
    assign borrow     = difference[8];
    assign equal      = (difference[7:0] == 8'h00);

    assign useIndexed = cs.extEnable && !cs.accessBit
                        && (cs.fileField <= `CS_INDEXED_LIMIT);
    assign accessAddr = (cs.fileField < `CS_ACCESS_SPLIT)
                        ? AW'({`CS_ACCESS_LOW_PAGE, cs.fileField})
                        : AW'({`CS_ACCESS_HIGH_PAGE, cs.fileField});
    assign bankAddr   = AW'({cs.bankSel, cs.fileField});
    assign indexAddr  = AW'(cs.indexBase + AW'(cs.fileField));

    assign cs.indexed = useIndexed;
    assign cs.address = useIndexed ? indexAddr : (cs.accessBit ? bankAddr : accessAddr);
    assign cs.skip    = (cs.kind == compare_skip_pkg::KIND_GREATER)
                        ? (!borrow && !equal)
                        : borrow;
endmodule

//--- tb_compare_skip_instructions.sv
// Self-checking bench for the compare-and-skip sequencer
`timescale 1ns/1ns
module tb_compare_skip_instructions;
    logic                        clk;
    logic                        rst_n;
    logic [15:0]                 instrWord;
    logic                        instrValid;
    logic                        nextTwoWord;
    logic [7:0]                  workingReg;
    logic [3:0]                  bankSelect;
    logic [11:0]                 indexBase;
    logic                        extEnable;
    logic [11:0]                 dataAddr;
    logic                        readStrobe;
    logic [7:0]                  dataIn;
    logic                        resultWrite;
    logic                        statusWrite;
    logic [3:0]                  quarter;
    compare_skip_pkg::activity_e activity;
    logic                        busy;
    logic                        done;
    logic                        skipTaken;
    logic                        flushFetched;
    logic                        nopCycle;
    logic                        indexedMode;
    logic [1:0]                  cycleCount;
    int                          badCount;
    int                          totalChecks;

    compare_skip_instructions dut_u (
        .clk          (clk),
        .rst_n        (rst_n),
        .instrWord    (instrWord),
        .instrValid   (instrValid),
        .nextTwoWord  (nextTwoWord),
        .workingReg   (workingReg),
        .bankSelect   (bankSelect),
        .indexBase    (indexBase),
        .extEnable    (extEnable),
        .dataAddr     (dataAddr),
        .readStrobe   (readStrobe),
        .dataIn       (dataIn),
        .resultWrite  (resultWrite),
        .statusWrite  (statusWrite),
        .quarter      (quarter),
        .activity     (activity),
        .busy         (busy),
        .done         (done),
        .skipTaken    (skipTaken),
        .flushFetched (flushFetched),
        .nopCycle     (nopCycle),
        .indexedMode  (indexedMode),
        .cycleCount   (cycleCount)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic testDone();
        if (badCount == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Bounded wait for the first quarter
    task automatic waitQ1();
        int n;
        n = 0;
        while (quarter !== 4'h1) begin
            tick();
            n++;
            if (n > 8) begin
                badCount++;
                testDone();
            end
        end
    endtask

    function automatic logic [11:0] addrOf(input logic acc, input logic [7:0] f,
        input logic [3:0] bank, input logic [11:0] base, input logic ext);
        if (acc) begin
            return {bank, f};
        end
        if (ext && f <= 8'h5f) begin
            return base + {4'h0, f};
        end
        return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
    endfunction

    // One compare from accept through its skip cycles
    task automatic runCompare(input logic [6:0] opc, input logic acc, input logic [7:0] f,
        input logic [3:0] bank, input logic [11:0] base, input logic ext, input logic [7:0] w,
        input logic [7:0] din, input logic two, input logic skip);
        logic idx;
        idx = !acc && ext && (f <= 8'h5f);
        waitQ1();
        instrWord = {opc, acc, f};
        instrValid = 1'b1;
        bankSelect = bank;
        indexBase = base;
        extEnable = ext;
        workingReg = w;
        dataIn = din;
        nextTwoWord = two;
        tick();
        instrValid = 1'b0;
        check(busy, 1'b1, "busy after accept");
        check(quarter, 4'h2, "quarter after decode");
        check(activity, compare_skip_pkg::ACT_DECODE, "decode quarter");
        tick();
        check(readStrobe, 1'b1, "read strobe");
        check(activity, compare_skip_pkg::ACT_READ, "read quarter");
        check(dataAddr, addrOf(acc, f, bank, base, ext), "operand address");
        check(indexedMode, idx, "indexed mode");
        tick();
        check(activity, compare_skip_pkg::ACT_PROCESS, "process quarter");
        check({resultWrite, statusWrite}, 2'b00, "write in last quarter");
        tick();
        check(done, 1'b1, "done pulse");
        check(skipTaken, skip, "skip decision");
        check(flushFetched, skip, "discard fetched");
        check(nopCycle, skip, "skip cycle start");
        check({resultWrite, statusWrite}, 2'b00, "write after compare");
        if (!skip) begin
            check(cycleCount, 2'h1, "plain cycle count");
        end else begin
            // Compare offered in a skip cycle must be ignored
            instrWord = {7'h32, 9'h000};
            instrValid = 1'b1;
            tick();
            instrValid = 1'b0;
            check(busy, 1'b0, "accepted during skip");
            check(activity, compare_skip_pkg::ACT_NOP, "skip cycle activity");
            check(done, 1'b0, "done held in skip");
            repeat (3) tick();
            check(nopCycle, two, "second skip cycle");
            if (two) begin
                repeat (4) tick();
            end
            check(nopCycle, 1'b0, "skip cycles over");
            check(cycleCount, two ? 2'h3 : 2'h2, "skip cycle count");
        end
    endtask

    // Boundaries of both compares, unsigned extremes included
    task automatic testCompareKinds();
        logic [7:0] ws [5] = '{8'h10, 8'h11, 8'h12, 8'h00, 8'hff};
        logic [7:0] ds [5] = '{8'h11, 8'h11, 8'h11, 8'hff, 8'h00};
        for (int i = 0; i < 5; i++) begin
            runCompare(7'h32, 1'b1, 8'h20, 4'h3, 12'h000, 1'b0, ws[i], ds[i], 1'b0,
                ds[i] > ws[i]);
            runCompare(7'h30, 1'b0, 8'h80, 4'h3, 12'h000, 1'b0, ws[i], ds[i], 1'b0,
                ds[i] < ws[i]);
        end
    endtask

    // Bank, access bank and indexed operand cases
    task automatic testAddressing();
        logic       as [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        logic       es [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [7:0] fs [6] = '{8'h5a, 8'h5f, 8'h60, 8'h05, 8'hff, 8'h00};
        for (int i = 0; i < 6; i++) begin
            runCompare(7'h30, as[i], fs[i], 4'ha, 12'h345, es[i], 8'h44, 8'h44, 1'b0,
                1'b0);
        end
    endtask

    // Compares before two-word instructions: two skip over them, one does not
    task automatic testTwoWord();
        runCompare(7'h32, 1'b1, 8'h01, 4'h1, 12'h000, 1'b0, 8'h00, 8'h80, 1'b1, 1'b1);
        runCompare(7'h30, 1'b1, 8'h02, 4'h2, 12'h000, 1'b0, 8'h80, 8'h7f, 1'b1, 1'b1);
        runCompare(7'h30, 1'b1, 8'h03, 4'h2, 12'h000, 1'b0, 8'h80, 8'h90, 1'b1, 1'b0);
    endtask

    // Reset in the middle of a skipping compare, then a clean compare
    task automatic testMidReset();
        waitQ1();
        instrWord = {7'h32, 9'h100};
        instrValid = 1'b1;
        workingReg = 8'h00;
        dataIn = 8'h01;
        nextTwoWord = 1'b1;
        tick();
        instrValid = 1'b0;
        repeat (2) tick();
        rst_n = 1'b0;
        tick();
        rst_n = 1'b1;
        check(busy, 1'b0, "busy after mid reset");
        check(quarter, 4'h1, "quarter after mid reset");
        check(nopCycle, 1'b0, "skip cycle after mid reset");
        check(done, 1'b0, "done after mid reset");
        runCompare(7'h30, 1'b1, 8'h07, 4'h5, 12'h000, 1'b0, 8'h20, 8'h1f, 1'b0, 1'b1);
    endtask

    // Foreign opcodes and compares outside the first quarter
    task automatic testRefused();
        logic [6:0] ops [3] = '{7'h31, 7'h33, 7'h22};
        for (int i = 0; i < 3; i++) begin
            waitQ1();
            instrWord = {ops[i], 9'h110};
            instrValid = 1'b1;
            tick();
            instrValid = 1'b0;
            check(busy, 1'b0, "foreign opcode accepted");
        end
        waitQ1();
        tick();
        instrWord = {7'h32, 9'h110};
        instrValid = 1'b1;
        tick();
        instrValid = 1'b0;
        repeat (2) tick();
        check(busy, 1'b0, "accepted outside first quarter");
    endtask

    initial begin
        badCount = 0;
        totalChecks = 0;
        rst_n = 1'b0;
        instrWord = 16'h0000;
        instrValid = 1'b0;
        nextTwoWord = 1'b0;
        workingReg = 8'h00;
        bankSelect = 4'h0;
        indexBase = 12'h000;
        extEnable = 1'b0;
        dataIn = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check(cycleCount, 2'h0, "cycle count after reset");
        check(done, 1'b0, "done after reset");
        testCompareKinds();
        testAddressing();
        testTwoWord();
        testMidReset();
        testRefused();
        testDone();
    end
endmodule
